// [include/adsq_pkg.sv]
// Constants, types and register map of the converter sequencing control.
// Assumes a plain byte-wide register port and a system clock of 200 MHz.
package adsq_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam int ADSQ_AW = 3;
	localparam logic [2:0] ADSQ_ADDR_INSEL = 3'h0;
	localparam logic [2:0] ADSQ_ADDR_CTRLA = 3'h1;
	localparam logic [2:0] ADSQ_ADDR_RESL = 3'h2;
	localparam logic [2:0] ADSQ_ADDR_RESH = 3'h3;
	localparam logic [2:0] ADSQ_ADDR_CTRLB = 3'h4;
	localparam logic [7:0] ADSQ_RST_BYTE = 8'h00;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int ADSQ_A_ON = 7;
	localparam int ADSQ_A_START = 6;
	localparam int ADSQ_A_AUTO = 5;
	localparam int ADSQ_A_FLAG = 4;
	localparam int ADSQ_A_IE = 3;
	localparam int ADSQ_I_LJ = 5;
	// ****************************************
	// Timing and channel codes
	// ****************************************
	localparam logic [4:0] ADSQ_LAST_FIRST = 5'h18;
	localparam logic [4:0] ADSQ_LAST_NORMAL = 5'h0C;
	localparam logic [6:0] ADSQ_DIV_MASK [8] = '{7'h01, 7'h01, 7'h03, 7'h07,
		7'h0F, 7'h1F, 7'h3F, 7'h7F};
	localparam logic [4:0] ADSQ_CH_SE_MAX = 5'h07;
	localparam logic [4:0] ADSQ_CH_D1_LO = 5'h10;
	localparam logic [4:0] ADSQ_CH_D1_HI = 5'h17;
	localparam logic [4:0] ADSQ_CH_D2_LO = 5'h18;
	localparam logic [4:0] ADSQ_CH_D2_HI = 5'h1D;
	localparam logic [4:0] ADSQ_CH_BG = 5'h1E;
	localparam logic [4:0] ADSQ_CH_GND = 5'h1F;
	localparam logic [2:0] ADSQ_NEG_D1 = 3'h1;
	localparam logic [2:0] ADSQ_NEG_D2 = 3'h2;
	localparam logic [2:0] ADSQ_TS_FREE = 3'h0;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ADSQ_IDLE = 2'b01,
		ADSQ_CONV = 2'b10
	} adsq_state_e;
	typedef struct packed {
		logic valid;
		logic diff;
		logic bandgap;
		logic ground;
		logic [2:0] pos;
		logic [2:0] neg;
	} adsq_route_s;
endpackage

// [hw/adsq_control.sv]
// Sequencing control of a 10-bit successive-approximation converter.
// Assumes the analog core presents its result on i_sample_value at completion,
// and that trigger flags and the register port are synchronous to i_sys_clk.
// Summary of operation
// - A channel written mid-conversion is applied only after that conversion completes.
// - Codes 0 to 7 pick single-ended inputs; codes 8 to 15 are unavailable.
// - Codes 16-23 pair inputs 0-7 against 1; codes 24-29 pair 0-5 against 2.
// - Code 30 connects the bandgap, code 31 connects ground.
// - Converter-on enables; clearing it switches off and aborts any conversion.
// - Start bit starts each single conversion, or the first free-running one.
// - First conversion after enabling takes 25 converter clocks, later ones 13.
// - Start bit reads one while converting; writing zero does nothing.
// - With auto-trigger on, each rising trigger edge while idle starts a conversion.
// - Completion flag sets when a conversion finishes, even if a pending low-byte read blocks the result update.
// - Flag clears on interrupt acknowledge or a written one; zero leaves it.
// - Interrupt requested only when flag, enable and global enable are all set.
// - Divider field gives 2,2,4,8,16,32,64,128 for the converter clock.
// - Right justified: high byte holds bits 9:8 low, low byte bits 7:0.
// - Left justified: high byte holds bits 9:2, low byte bits 1:0 on top.
// - Reading the low byte blocks result updates until the high byte is read.
// - Justification change alters presentation at once, even mid-conversion.
// - Source zero is free running; switching to it gives no trigger event.
// - Switching from a clear to a set trigger source counts as a rising edge.
`timescale 1ns/1ps
module adsq_control
	import adsq_pkg::*;
#(
	parameter int RES_W = 10
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	input wire logic [ADSQ_AW-1:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	output logic [7:0] o_rd_data,
	input wire logic [RES_W-1:0] i_sample_value,
	input wire logic [7:0] i_trigger_flags,
	input wire logic i_global_irq_enable,
	input wire logic i_irq_ack,
	output logic o_irq,
	output logic o_converter_on,
	output logic o_converting,
	output adsq_route_s o_route,
	output logic [1:0] o_reference_select
);
	// ****************************************
	// Register state
	// ****************************************
	logic on_q;
	logic auto_q;
	logic ie_q;
	logic flag_q;
	logic [2:0] div_q;
	logic lj_q;
	logic [4:0] chsel_q;
	logic [1:0] ref_q;
	logic [2:0] ts_q;
	logic lock_q;
	logic [RES_W-1:0] result_q;
	logic [7:0] rdata_q;
	adsq_state_e state_q;
	logic [6:0] pre_q;
	logic [4:0] cyc_q;
	logic [4:0] last_q;
	logic init_q;
	logic trig_prev_q;
	adsq_route_s route_q;

	// ****************************************
	// Decode of strobes and events
	// ****************************************
	logic wr_insel;
	logic wr_a;
	logic wr_b;
	logic rd_low;
	logic rd_high;
	logic on_d;
	logic tick;
	logic conv_done;
	logic trig_level;
	logic trig_edge;
	logic sw_start;
	logic free_next;
	logic start_req;
	logic [7:0] res_high;
	logic [7:0] res_low;
	logic [7:0] res_high_lj;

	// Strobe qualification
	assign wr_insel = i_clk_en && i_wr_en && (i_addr == ADSQ_ADDR_INSEL);
	assign wr_a = i_clk_en && i_wr_en && (i_addr == ADSQ_ADDR_CTRLA);
	assign wr_b = i_clk_en && i_wr_en && (i_addr == ADSQ_ADDR_CTRLB);
	assign rd_low = i_clk_en && i_rd_en && (i_addr == ADSQ_ADDR_RESL);
	assign rd_high = i_clk_en && i_rd_en && (i_addr == ADSQ_ADDR_RESH);
	assign on_d = wr_a ? i_wr_data[ADSQ_A_ON] : on_q;

	// Converter clock tick from the prescaler
	assign tick = i_clk_en && on_q && ((pre_q & ADSQ_DIV_MASK[div_q]) == ADSQ_DIV_MASK[div_q]);
	assign conv_done = (state_q == ADSQ_CONV) && tick && (cyc_q == last_q) && on_d;

	// Trigger selection; free running source counts as a clear level
	assign trig_level = (ts_q == ADSQ_TS_FREE) ? 1'b0 : i_trigger_flags[ts_q];
	assign trig_edge = i_clk_en && auto_q && trig_level && !trig_prev_q;
	assign sw_start = wr_a && i_wr_data[ADSQ_A_START];
	assign free_next = conv_done && auto_q && (ts_q == ADSQ_TS_FREE);
	assign start_req = on_d && (state_q == ADSQ_IDLE) && (sw_start || trig_edge);

	// Result presentation follows the live justification bit
	assign res_high_lj = result_q[9:2];
	assign res_high = lj_q ? res_high_lj : {6'h00, result_q[9:8]};
	assign res_low = lj_q ? {result_q[1:0], 6'h00} : result_q[7:0];

	// Channel code to analog routing
	function automatic adsq_route_s decode_route(input logic [4:0] code);
		adsq_route_s r;
		r = '0;
		if (code <= ADSQ_CH_SE_MAX) begin
			r.valid = 1'b1;
			r.pos = code[2:0];
		end else if ((code >= ADSQ_CH_D1_LO) && (code <= ADSQ_CH_D1_HI)) begin
			r.valid = 1'b1;
			r.diff = 1'b1;
			r.pos = code[2:0];
			r.neg = ADSQ_NEG_D1;
		end else if ((code >= ADSQ_CH_D2_LO) && (code <= ADSQ_CH_D2_HI)) begin
			r.valid = 1'b1;
			r.diff = 1'b1;
			r.pos = code[2:0];
			r.neg = ADSQ_NEG_D2;
		end else if (code == ADSQ_CH_BG) begin
			r.valid = 1'b1;
			r.bandgap = 1'b1;
		end else if (code == ADSQ_CH_GND) begin
			r.valid = 1'b1;
			r.ground = 1'b1;
		end
		return r;
	endfunction

	// ****************************************
	// Control register A fields
	// ****************************************
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			on_q <= 1'b0;
			auto_q <= 1'b0;
			ie_q <= 1'b0;
			div_q <= 3'h0;
		end else if (wr_a) begin
			on_q <= i_wr_data[ADSQ_A_ON];
			auto_q <= i_wr_data[ADSQ_A_AUTO];
			ie_q <= i_wr_data[ADSQ_A_IE];
			div_q <= i_wr_data[2:0];
		end
	end

	// Completion flag; a completion beats a clear in the same cycle
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			flag_q <= 1'b0;
		end else if (conv_done) begin
			flag_q <= 1'b1;
		end else if (i_clk_en && (i_irq_ack || (wr_a && i_wr_data[ADSQ_A_FLAG]))) begin
			flag_q <= 1'b0;
		end
	end

	// Input select and control register B
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			ref_q <= 2'h0;
			lj_q <= 1'b0;
			chsel_q <= 5'h00;
			ts_q <= 3'h0;
		end else begin
			if (wr_insel) begin
				ref_q <= i_wr_data[7:6];
				lj_q <= i_wr_data[ADSQ_I_LJ];
				chsel_q <= i_wr_data[4:0];
			end
			if (wr_b) begin
				ts_q <= i_wr_data[2:0];
			end
		end
	end

	// ****************************************
	// Prescaler and trigger history
	// ****************************************
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			pre_q <= 7'h00;
			trig_prev_q <= 1'b0;
		end else if (i_clk_en) begin
			pre_q <= on_q ? pre_q + 7'h01 : 7'h00;
			trig_prev_q <= trig_level;
		end
	end

	// ****************************************
	// Conversion sequencer
	// ****************************************
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			state_q <= ADSQ_IDLE;
			cyc_q <= 5'h00;
			last_q <= ADSQ_LAST_NORMAL;
			init_q <= 1'b1;
		end else if (i_clk_en) begin
			if (!on_d) begin
				state_q <= ADSQ_IDLE;
				init_q <= 1'b1;
				cyc_q <= 5'h00;
			end else begin
				case (state_q)
					ADSQ_IDLE: begin
						if (start_req) begin
							state_q <= ADSQ_CONV;
							cyc_q <= 5'h00;
							last_q <= init_q ? ADSQ_LAST_FIRST : ADSQ_LAST_NORMAL;
							init_q <= 1'b0;
						end
					end
					ADSQ_CONV: begin
						if (conv_done) begin
							cyc_q <= 5'h00;
							last_q <= ADSQ_LAST_NORMAL;
							state_q <= free_next ? ADSQ_CONV : ADSQ_IDLE;
						end else if (tick) begin
							cyc_q <= cyc_q + 5'h01;
						end
					end
					default: begin
						state_q <= ADSQ_IDLE;
					end
				endcase
			end
		end
	end

	// Applied routing follows the select only between conversions
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			route_q <= decode_route(5'h00);
		end else if (i_clk_en && ((state_q == ADSQ_IDLE) || conv_done)) begin
			route_q <= decode_route(chsel_q);
		end
	end

	// ****************************************
	// Result register and read lock
	// ****************************************
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			lock_q <= 1'b0;
		end else if (rd_low) begin
			lock_q <= 1'b1;
		end else if (rd_high) begin
			lock_q <= 1'b0;
		end
	end

	// Capture at completion unless the low byte is pending
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			result_q <= '0;
		end else if (conv_done && !lock_q) begin
			result_q <= i_sample_value;
		end
	end

	// ****************************************
	// Read data, one cycle after the strobe
	// ****************************************
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			rdata_q <= ADSQ_RST_BYTE;
		end else if (i_clk_en && i_rd_en) begin
			if (i_addr == ADSQ_ADDR_INSEL) begin
				rdata_q <= {ref_q, lj_q, chsel_q};
			end else if (i_addr == ADSQ_ADDR_CTRLA) begin
				rdata_q <= {on_q, (state_q == ADSQ_CONV), auto_q, flag_q, ie_q, div_q};
			end else if (i_addr == ADSQ_ADDR_RESL) begin
				rdata_q <= res_low;
			end else if (i_addr == ADSQ_ADDR_RESH) begin
				rdata_q <= res_high;
			end else if (i_addr == ADSQ_ADDR_CTRLB) begin
				rdata_q <= {5'h00, ts_q};
			end else begin
				rdata_q <= ADSQ_RST_BYTE;
			end
		end
	end

	// Outputs
	assign o_rd_data = rdata_q;
	assign o_irq = flag_q && ie_q && i_global_irq_enable;
	assign o_converter_on = on_q;
	assign o_converting = (state_q == ADSQ_CONV);
	assign o_route = route_q;
	assign o_reference_select = ref_q;

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_read_high_lj;
		rd_high && lj_q;
	endsequence
	sequence s_high_lj_shown;
		o_rd_data == $past(res_high_lj);
	endsequence

	// Interrupt acknowledge drops the request unless a completion lands
	property p_ack_clear;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_clk_en && i_irq_ack && !conv_done) |=> (!flag_q && !o_irq);
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear flag");

	property p_flag_set;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		conv_done |=> flag_q;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set at completion");

	property p_off_abort;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(wr_a && !i_wr_data[ADSQ_A_ON]) |=> (state_q == ADSQ_IDLE) && !o_converter_on;
	endproperty
	a_off_abort: assert property (p_off_abort) else $error("turn off did not abort");

	property p_length;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(start_req && init_q) |=> (last_q == ADSQ_LAST_FIRST);
	endproperty
	a_length: assert property (p_length) else $error("first conversion not 25 clocks");

	property p_busy_read;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(o_converting && i_clk_en && i_rd_en && (i_addr == ADSQ_ADDR_CTRLA))
			|=> o_rd_data[ADSQ_A_START];
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("start bit low while busy");

	property p_lock_hold;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		lock_q |=> $stable(result_q);
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("result changed while locked");

	property p_route_hold;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(o_converting && !conv_done) |=> $stable(route_q);
	endproperty
	a_route_hold: assert property (p_route_hold) else $error("route changed mid conversion");

	property p_left_read;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_read_high_lj |=> s_high_lj_shown;
	endproperty
	a_left_read: assert property (p_left_read) else $error("left justified high byte wrong");

	property p_free_run;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		free_next |=> o_converting && (cyc_q == 5'h00);
	endproperty
	a_free_run: assert property (p_free_run) else $error("free running did not restart");
endmodule

// [test/adsq_testbench.sv]
// Self-checking bench for the converter sequencing control.
// Assumes the adsq_pkg register map and a 200 MHz system clock.
`timescale 1ns/1ps
module testbench;
	import adsq_pkg::*;
	logic i_sys_clk = 0, i_reset_n = 0, i_clk_en = 1, i_wr_en = 0, i_rd_en = 0;
	logic i_global_irq_enable = 0, i_irq_ack = 0;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wr_data = 8'h00, i_trigger_flags = 8'h00, o_rd_data;
	logic [9:0] i_sample_value = 10'h000;
	logic o_irq, o_converter_on, o_converting;
	adsq_route_s o_route;
	logic [1:0] o_reference_select;
	int fails = 0, n_checks = 0, n;
	// ****************************************
	// Clock, device and common tasks
	// ****************************************
	always #2.5 i_sys_clk = ~i_sys_clk;
	adsq_control adsq_control_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
		.i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_sample_value(i_sample_value),
		.i_trigger_flags(i_trigger_flags), .i_global_irq_enable(i_global_irq_enable),
		.i_irq_ack(i_irq_ack), .o_irq(o_irq), .o_converter_on(o_converter_on),
		.o_converting(o_converting), .o_route(o_route),
		.o_reference_select(o_reference_select));
	// Value compare, counted
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One-cycle register write
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr_en <= 1'h1;
		i_addr <= a;
		i_wr_data <= d;
		@(posedge i_sys_clk);
		i_wr_en <= 1'h0;
	endtask
	// One-cycle register read, data judged in the following cycle
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
		@(posedge i_sys_clk);
		i_rd_en <= 1'h1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd_en <= 1'h0;
		#1;
		chk(nm, {8'h00, e}, {8'h00, o_rd_data});
	endtask
	// Cycles until the busy output drops, bounded
	task automatic wait_done(output int c);
		c = 0;
		#1;
		while (o_converting === 1'h1 && c < 2000) begin
			@(posedge i_sys_clk);
			#1;
			c++;
		end
		if (c >= 2000) fails++;
	endtask
	// Expected route as {mask, value}
	function automatic logic [19:0] rexp(input logic [4:0] c);
		if (c <= 5'h07) return {10'h3FF, 4'h8, c[2:0], 3'h0};
		if (c < 5'h10) return {10'h200, 10'h000};
		if (c < 5'h18) return {10'h3FF, 4'hC, c[2:0], 3'h1};
		if (c < 5'h1E) return {10'h3FF, 4'hC, c[2:0], 3'h2};
		return {10'h3C0, 2'h2, c == 5'h1E, c == 5'h1F, 6'h00};
	endfunction
	task automatic test_done;
		if (fails == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		for (int a = 0; a < 6; a++) rd(a[2:0], 8'h00, "reset_reg");
		chk("reset_route", 16'h0200, {6'h00, o_route});
	endtask
	task automatic t_route;
		logic [19:0] x;
		for (int c = 0; c < 32; c++) begin
			wr(3'h0, c[7:0]);
			repeat (2) @(posedge i_sys_clk);
			#1;
			x = rexp(c[4:0]);
			chk("route", {6'h00, x[9:0]}, {6'h00, o_route & x[19:10]});
		end
		// Reference bits are stored and shown on their own output
		wr(3'h0, 8'hC0);
		#1;
		chk("ref_sel", 16'h3, {14'h0, o_reference_select});
		rd(3'h0, 8'hC0, "insel_rd");
	endtask
	task automatic t_conv;
		wr(3'h0, 8'h00);
		i_sample_value <= 10'h3A3;
		wr(3'h1, 8'hC0);
		wait_done(n);
		chk("first_len", 16'h1, {15'h0, n >= 47 && n <= 53});
		rd(3'h1, 8'h90, "ctrl_done");
		rd(3'h2, 8'hA3, "res_low_r");
		rd(3'h3, 8'h03, "res_high_r");
		wr(3'h0, 8'h20);
		rd(3'h2, 8'hC0, "res_low_l");
		rd(3'h3, 8'hE8, "res_high_l");
		wr(3'h1, 8'hD2);
		i_sample_value <= 10'h155;
		wait_done(n);
		chk("next_len", 16'h1, {15'h0, n >= 49 && n <= 55});
		rd(3'h3, 8'h55, "res_high_2");
	endtask
	task automatic t_lock;
		rd(3'h2, 8'h40, "lock_low");
		wr(3'h1, 8'hD0);
		i_sample_value <= 10'h2AA;
		wait_done(n);
		rd(3'h1, 8'h90, "flag_locked");
		rd(3'h3, 8'h55, "held_high");
		wr(3'h1, 8'hD0);
		wait_done(n);
		rd(3'h3, 8'hAA, "new_high");
		rd(3'h2, 8'h80, "new_low");
	endtask
	task automatic t_irq;
		wr(3'h1, 8'h88);
		rd(3'h1, 8'h98, "flag_w0");
		chk("irq_gie0", 16'h0, {15'h0, o_irq});
		@(posedge i_sys_clk);
		i_global_irq_enable <= 1'h1;
		@(posedge i_sys_clk);
		#1;
		chk("irq_on", 16'h1, {15'h0, o_irq});
		@(posedge i_sys_clk);
		i_irq_ack <= 1'h1;
		@(posedge i_sys_clk);
		i_irq_ack <= 1'h0;
		@(posedge i_sys_clk);
		#1;
		chk("irq_ack", 16'h0, {15'h0, o_irq});
		wr(3'h1, 8'hC8);
		wait_done(n);
		@(posedge i_sys_clk);
		#1;
		chk("irq_again", 16'h1, {15'h0, o_irq});
		wr(3'h1, 8'h90);
		rd(3'h1, 8'h80, "flag_w1");
		chk("irq_ie0", 16'h0, {15'h0, o_irq});
	endtask
	task automatic t_mux_abort;
		wr(3'h0, 8'h03);
		wr(3'h1, 8'hC0);
		wr(3'h0, 8'h05);
		repeat (3) @(posedge i_sys_clk);
		#1;
		chk("route_held", 16'h3, {13'h0, o_route.pos});
		// Clock enable low freezes the conversion and refuses strobes
		@(posedge i_sys_clk);
		i_clk_en <= 1'h0;
		wr(3'h0, 8'h07);
		repeat (58) @(posedge i_sys_clk);
		#1;
		chk("frozen", 16'h1, {15'h0, o_converting});
		@(posedge i_sys_clk);
		i_clk_en <= 1'h1;
		wait_done(n);
		repeat (2) @(posedge i_sys_clk);
		#1;
		chk("route_new", 16'h5, {13'h0, o_route.pos});
		wr(3'h1, 8'hD0);
		repeat (4) @(posedge i_sys_clk);
		wr(3'h1, 8'h00);
		repeat (40) @(posedge i_sys_clk);
		rd(3'h1, 8'h00, "aborted");
		chk("off", 16'h0, {14'h0, o_converter_on, o_converting});
	endtask
	task automatic t_auto;
		wr(3'h4, 8'h01);
		wr(3'h1, 8'hA0);
		repeat (4) @(posedge i_sys_clk);
		#1;
		chk("no_trig", 16'h0, {15'h0, o_converting});
		@(posedge i_sys_clk);
		i_trigger_flags <= 8'h02;
		repeat (3) @(posedge i_sys_clk);
		#1;
		chk("trig_edge", 16'h1, {15'h0, o_converting});
		wait_done(n);
		@(posedge i_sys_clk);
		i_trigger_flags <= 8'h04;
		wr(3'h4, 8'h02);
		repeat (3) @(posedge i_sys_clk);
		#1;
		chk("src_switch", 16'h1, {15'h0, o_converting});
		wait_done(n);
		wr(3'h4, 8'h00);
		repeat (10) @(posedge i_sys_clk);
		#1;
		chk("to_free", 16'h0, {15'h0, o_converting});
		wr(3'h1, 8'hF0);
		repeat (5) @(posedge i_sys_clk);
		wr(3'h1, 8'hA0);
		repeat (100) @(posedge i_sys_clk);
		#1;
		chk("free_run", 16'h1, {15'h0, o_converting});
		rd(3'h1, 8'hF0, "free_flag");
		wr(3'h1, 8'h10);
	endtask
	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		repeat (6) @(posedge i_sys_clk);
		i_reset_n <= 1'h1;
		t_reset();
		t_route();
		t_conv();
		t_lock();
		t_irq();
		t_mux_abort();
		t_auto();
		test_done();
	end
	initial begin
		#100000;
		fails++;
		test_done();
	end
endmodule
